/* File: bench/dsp_gain_io_ctrl_assertions.sv */
// Purpose: port checks for the gain and io control bank
// Assumes: config register mirrored from bus writes
// Notes: bound into every instance of the bank
`timescale 1ns/100ps

module dsp_gain_io_ctrl_assertions
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tone_active,
  input wire logic send_bit,
  input wire logic tone_bit,
  input wire logic si_pin,
  input wire logic so_pin,
  input wire logic rx_bit,
  input wire dsp_ctrl_pkg::gain_s dsp_gain,
  input wire logic [3:0] rx_atten,
  input wire logic [3:0] tx_atten,
  input wire dsp_ctrl_pkg::io_ctrl_s io_ctrl,
  input wire dsp_ctrl_pkg::path_en_s path_en
);
  logic [1:0] cfg_q;
  logic [7:0] cmd;
  logic cmd_wr;
  logic so_exp;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // mirror of bit order and force-low
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cfg_q <= 2'h2;
    else if (reg_wr && reg_addr == 4'h3)
      cfg_q <= reg_wdata[1:0];
  end

  // command byte in msb-first order
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      cmd[i] = cfg_q[0] ? reg_wdata[7 - i] : reg_wdata[i];
  end

  // expected serial output ahead of its register
  assign cmd_wr = reg_wr && reg_addr == 4'h0;
  assign so_exp = !cfg_q[1] && io_ctrl.serial_out_drive &&
    (io_ctrl.send_filter_run ? send_bit : io_ctrl.tone_path_connect && tone_bit);

  gain_load_a: assert property (
    cmd_wr && cmd[7:5] == 3'h2 |=> dsp_gain == $past(cmd[4:0]))
    else $error("gain field not loaded");
  gain_keep_a: assert property (
    cmd_wr && cmd[7:5] != 3'h2 |=> $stable(dsp_gain))
    else $error("gain field changed by other command");
  io_load_a: assert property (
    cmd_wr && cmd[7:4] == 4'h6 |=> io_ctrl == $past(cmd[3:0]))
    else $error("io field not loaded");
  io_keep_a: assert property (
    cmd_wr && cmd[7:4] != 4'h6 |=> $stable(io_ctrl))
    else $error("io field changed by other command");
  atten_map_a: assert property (
    tx_atten == {1'b0, $past(dsp_gain.tx_step)} &&
    rx_atten == {1'b0, $past(dsp_gain.rx_step), 1'b0})
    else $error("attenuation step mismatch");
  so_gate_a: assert property (so_pin == $past(so_exp))
    else $error("serial output gating wrong");
  rx_gate_a: assert property (
    rx_bit == $past(io_ctrl.serial_in_accept && !cfg_q[1] && si_pin))
    else $error("serial input gating wrong");
  tone_path_a: assert property (
    path_en.tone_to_send == $past(!io_ctrl.send_filter_run && io_ctrl.tone_path_connect)
    && path_en.tone_to_receive == $past(io_ctrl.tone_path_connect))
    else $error("tone path enables wrong");
  gain_view_a: assert property (
    reg_rd && reg_addr == 4'h1 |=> reg_rdata == {3'h2, $past(dsp_gain)})
    else $error("gain view readback wrong");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not cleared");
endmodule : dsp_gain_io_ctrl_assertions

bind dsp_gain_io_ctrl dsp_gain_io_ctrl_assertions chk (.clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tone_active, .send_bit, .tone_bit,
  .si_pin, .so_pin, .rx_bit, .dsp_gain, .rx_atten, .tx_atten, .io_ctrl, .path_en);

/* File: bench/host_model.sv */
// Purpose: host controller writing command bytes over the register port
// Assumes: tasks are called by the bench just after a rising or a falling edge
// Notes: releases write data to its inverse between writes
`timescale 1ns/100ps

module host_model
(
  input wire logic clk,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  logic lsb_mode;

  // idle strobes at time zero; address and data follow the first task
  initial
  begin
    lsb_mode = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic cmd(input logic [7:0] d);
    logic [7:0] w;
    for (int i = 0; i < 8; i++)
      w[i] = lsb_mode ? d[7 - i] : d[i];
    wr(4'h0, w);
  endtask : cmd

  // config write also sets the bit order used for commands
  task automatic cfg(input logic [7:0] d);
    lsb_mode = d[0];
    wr(4'h3, d);
  endtask : cfg
endmodule : host_model

/* File: bench/tb_dsp_gain_io_ctrl.sv */
// Purpose: self-checking bench for the gain and io control bank
// Assumes: host model drives the register port
// Notes: tone stays idle while the tone path is switched
`timescale 1ns/100ps

module tb_dsp_gain_io_ctrl;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic tone_active = 1'b0;
  logic send_bit;
  logic tone_bit;
  logic si_pin;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic so_pin;
  logic rx_bit;
  logic [3:0] rx_atten;
  logic [3:0] tx_atten;
  dsp_ctrl_pkg::gain_s dsp_gain;
  dsp_ctrl_pkg::io_ctrl_s io_ctrl;
  dsp_ctrl_pkg::path_en_s path_en;
  int fails = 0;
  int n_tests = 0;

  // clock and parts
  always #5 clk = ~clk;

  host_model host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  dsp_gain_io_ctrl dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .tone_active, .send_bit, .tone_bit, .si_pin, .so_pin, .rx_bit,
    .dsp_gain, .rx_atten, .tx_atten, .io_ctrl, .path_en);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // reset views and an unmapped read
  task automatic t_reset;
    logic [7:0] d;
    host.rd(4'h1, d);
    chk(d, 8'h40);
    host.rd(4'h2, d);
    chk(d, 8'h60);
    host.rd(4'hF, d);
    chk(d, 8'h00);
  endtask : t_reset

  // every permitted io code, with serial bits toggled
  task automatic t_io;
    logic [7:0] codes [10] = '{8'h60, 8'h61, 8'h64, 8'h65, 8'h66, 8'h67, 8'h6E,
      8'h6F, 8'h6A, 8'h6B};
    logic [7:0] c;
    for (int k = 0; k < 10; k++)
    begin
      c = codes[k];
      host.cmd(c);
      @(negedge clk);
      chk({4'h0, io_ctrl}, {4'h0, c[3:0]});
      @(negedge clk);
      chk({6'h0, path_en.tone_to_send, path_en.tone_to_receive},
        {6'h0, !c[3] && c[2], c[2]});
      chk({6'h0, path_en.send_proc_run, path_en.receive_in_run},
        {6'h0, c[1], c[0]});
      for (int b = 0; b < 4; b++)
      begin
        @(posedge clk);
        send_bit <= b[0];
        tone_bit <= b[1];
        si_pin <= b[0] ^ b[1];
        @(posedge clk);
        @(negedge clk);
        chk({7'h0, so_pin}, {7'h0, c[1] && (c[3] ? b[0] : c[2] && b[1])});
        chk({7'h0, rx_bit}, {7'h0, c[0] && (b[0] ^ b[1])});
      end
    end
  endtask : t_io

  // all gain codes, io field left alone
  task automatic t_gain;
    for (int i = 0; i < 32; i++)
    begin
      host.cmd(8'h40 | 8'(i));
      @(negedge clk);
      chk({3'h0, dsp_gain}, 8'(i));
      @(negedge clk);
      chk({4'h0, tx_atten}, 8'(i % 8));
      chk({4'h0, rx_atten}, 8'((i / 8) * 2));
      chk({4'h0, io_ctrl}, 8'h0B);
    end
  endtask : t_gain

  // commands sent least significant bit first
  task automatic t_lsb;
    host.cfg(8'h01);
    host.cmd(8'h4D);
    @(negedge clk);
    chk({3'h0, dsp_gain}, 8'h0D);
    host.cmd(8'h6A);
    @(negedge clk);
    chk({4'h0, io_ctrl}, 8'h0A);
    host.cfg(8'h00);
    host.cmd(8'h6B);
  endtask : t_lsb

  // force-low test bit overrides both serial pins
  task automatic t_force;
    host.cfg(8'h02);
    send_bit <= 1'b1;
    si_pin <= 1'b1;
    repeat (2) @(negedge clk);
    chk({6'h0, so_pin, rx_bit}, 8'h00);
    host.cfg(8'h00);
    repeat (2) @(negedge clk);
    chk({6'h0, so_pin, rx_bit}, 8'h03);
  endtask : t_force

  // unknown prefix leaves both registers alone
  task automatic t_bad;
    logic [7:0] d;
    host.cmd(8'h80);
    host.rd(4'h1, d);
    chk(d, 8'h4D);
    host.rd(4'h2, d);
    chk(d, 8'h6B);
  endtask : t_bad

  // sticky status, clear, and tone path held steady while a tone plays
  task automatic t_status;
    logic [7:0] d;
    host.rd(4'h4, d);
    chk(d, 8'h01);
    host.wr(4'h4, 8'h07);
    host.rd(4'h4, d);
    chk(d, 8'h00);
    @(posedge clk);
    // tone connect kept while the tone plays
    tone_active <= 1'b1;
    host.cmd(8'h6A);
    host.rd(4'h4, d);
    chk(d, 8'h00);
    host.rd(4'h2, d);
    chk(d, 8'h6A);
    @(posedge clk);
    // tone connect switched only with the tone idle
    tone_active <= 1'b0;
    host.cmd(8'h6F);
    host.rd(4'h4, d);
    chk(d, 8'h00);
    host.rd(4'h2, d);
    chk(d, 8'h6F);
    host.rd(4'h3, d);
    chk(d, 8'h00);
  endtask : t_status

  // main sequence; force-low cleared before serial output is used
  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    host.cfg(8'h00);
    t_io();
    t_gain();
    t_lsb();
    t_force();
    t_bad();
    t_status();
    conclude();
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule : tb_dsp_gain_io_ctrl

/* File: inc/dsp_ctrl_map.svh */
// Purpose: offsets, field positions, reset values and command prefixes
//          of the signal processor gain and io control bank
// Assumes: 4-bit word index on the plain register port, 8-bit data
// Notes: definitions only
`ifndef DSP_CTRL_MAP_SVH
`define DSP_CTRL_MAP_SVH

// ----------------------------------------------------------------
// register offsets (word index)
// ----------------------------------------------------------------
`define OFF_COMMAND 4'h0
`define OFF_GAIN_VIEW 4'h1
`define OFF_IO_VIEW 4'h2
`define OFF_CONFIG 4'h3
`define OFF_STATUS 4'h4

// ----------------------------------------------------------------
// command byte decode
// ----------------------------------------------------------------
`define GAIN_PREFIX 3'h2
`define IO_PREFIX 4'h6

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define GAIN_RX_MSB 4
`define GAIN_RX_LSB 3
`define GAIN_TX_MSB 2
`define GAIN_TX_LSB 0
`define IO_FILTER_BIT 3
`define IO_TONE_BIT 2
`define IO_OUT_BIT 1
`define IO_IN_BIT 0
`define CFG_LSB_FIRST_BIT 0
`define CFG_FORCE_LOW_BIT 1
`define STS_BAD_CMD_BIT 0
`define STS_INHIBIT_BIT 1
`define STS_TONE_LIVE_BIT 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GAIN_CMD_RESET 8'h40
`define IO_CMD_RESET 8'h60
`define CONFIG_RESET 8'h02

`endif

/* File: inc/dsp_ctrl_pkg.sv */
// Purpose: types shared by the gain and io control bank
// Assumes: nothing
// Notes: field order follows the command byte low bits
package dsp_ctrl_pkg;

  // ----------------------------------------------------------------
  // digital gain fields
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rx_step;
    logic [2:0] tx_step;
  } gain_s;

  // ----------------------------------------------------------------
  // io control fields
  // ----------------------------------------------------------------
  typedef struct packed {
    logic send_filter_run;
    logic tone_path_connect;
    logic serial_out_drive;
    logic serial_in_accept;
  } io_ctrl_s;

  // ----------------------------------------------------------------
  // derived path enables
  // ----------------------------------------------------------------
  typedef struct packed {
    logic send_proc_run;
    logic receive_in_run;
    logic tone_to_send;
    logic tone_to_receive;
  } path_en_s;

  // ----------------------------------------------------------------
  // command kind after decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_GAIN,
    CMD_IO
  } cmd_kind_e;

endpackage : dsp_ctrl_pkg

/* File: rtl/byte_order_fix.sv */
// Purpose: put a command byte into msb-first order
// Assumes: lsb_first is steady around the write
// Notes: pure combinational
`timescale 1ns/100ps

module byte_order_fix
(
  input wire logic [7:0] raw_byte,
  input wire logic lsb_first,
  output logic [7:0] msb_byte
);

  // ----------------------------------------------------------------
  // reversal
  // ----------------------------------------------------------------
  logic [7:0] flipped;

  // mirror the bits when the host sent lsb first
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      flipped[i] = raw_byte[7 - i];
    end
    msb_byte = lsb_first ? flipped : raw_byte;
  end

endmodule : byte_order_fix

/* File: rtl/dsp_gain_io_ctrl.sv */
// Purpose: digital gain and io control bank of the voice signal processor
// Assumes: single 100 MHz clock, synchronous active-high reset,
//          command bytes arrive through a plain register port
// Notes: command registers are write only; views give them back
//
// Functional notes
// - five-bit gain register selected by command prefix 010
// - send and receive gains change independently of each other
// - D4..D3 receive 0 to -2.4 dB; D2..D0 send 0 to -2.8 dB
// - command bytes may be sent msb first or lsb first, both agree
// - four-bit io control register selected by prefix 0110
// - send filter bit low stops send band-pass, high runs it
// - tone connect bit joins tone to send and receive paths
// - tone reaches send serial data only with filter 0, tone 1
// - serial out bit low holds output low, high shifts send data
// - serial in bit low reads input as low, high accepts data
// - serial force-low test bit holds output low over everything
// - serial out low stops send processing; tone-only stops receive; receive_in_run here follows the serial in bit alone
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "dsp_ctrl_map.svh"

module dsp_gain_io_ctrl
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tone_active,
  input wire logic send_bit,
  input wire logic tone_bit,
  input wire logic si_pin,
  output logic so_pin,
  output logic rx_bit,
  output dsp_ctrl_pkg::gain_s dsp_gain,
  output logic [3:0] rx_atten,
  output logic [3:0] tx_atten,
  output dsp_ctrl_pkg::io_ctrl_s io_ctrl,
  output dsp_ctrl_pkg::path_en_s path_en
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dsp_ctrl_pkg::gain_s gain_reg;
  dsp_ctrl_pkg::gain_s gain_next;
  dsp_ctrl_pkg::io_ctrl_s io_reg;
  dsp_ctrl_pkg::io_ctrl_s io_next;
  logic lsb_first_reg;
  logic lsb_first_next;
  logic force_low_reg;
  logic force_low_next;
  logic bad_cmd_reg;
  logic bad_cmd_next;
  logic inhibit_reg;
  logic inhibit_next;
  logic tone_live_reg;
  logic tone_live_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic so_reg;
  logic so_next;
  logic rx_reg;
  logic rx_next;
  dsp_ctrl_pkg::path_en_s path_reg;
  dsp_ctrl_pkg::path_en_s path_next;
  logic [3:0] rx_att_reg;
  logic [3:0] rx_att_next;
  logic [3:0] tx_att_reg;
  logic [3:0] tx_att_next;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [7:0] cmd_byte;
  logic cmd_wr;
  logic sts_wr;
  dsp_ctrl_pkg::cmd_kind_e cmd_kind;
  dsp_ctrl_pkg::io_ctrl_s cmd_io;
  logic cmd_inhibited;
  logic tone_switch_live;

  // bring the byte into msb-first order
  // bit order agreement
  byte_order_fix order_fix
  (
    .raw_byte(reg_wdata),
    .lsb_first(lsb_first_reg),
    .msb_byte(cmd_byte)
  );

  assign cmd_wr = reg_wr && (reg_addr == `OFF_COMMAND);
  assign sts_wr = reg_wr && (reg_addr == `OFF_STATUS);

  // classify the byte by its fixed upper bits
  // prefix decode
  always_comb
  begin
    cmd_kind = dsp_ctrl_pkg::CMD_NONE;
    if (cmd_wr)
    begin
      if (cmd_byte[7:5] == `GAIN_PREFIX)
      begin
        cmd_kind = dsp_ctrl_pkg::CMD_GAIN;
      end
      else if (cmd_byte[7:4] == `IO_PREFIX)
      begin
        cmd_kind = dsp_ctrl_pkg::CMD_IO;
      end
    end
  end

  // low nibble seen as io fields, plus hazard checks on it
  always_comb
  begin
    cmd_io.send_filter_run = cmd_byte[`IO_FILTER_BIT];
    cmd_io.tone_path_connect = cmd_byte[`IO_TONE_BIT];
    cmd_io.serial_out_drive = cmd_byte[`IO_OUT_BIT];
    cmd_io.serial_in_accept = cmd_byte[`IO_IN_BIT];
    cmd_inhibited = (!cmd_io.send_filter_run && cmd_io.serial_out_drive
                     && !cmd_io.tone_path_connect)
                    || (cmd_io.send_filter_run && !cmd_io.serial_out_drive);
    tone_switch_live = tone_active
                       && (cmd_io.tone_path_connect != io_reg.tone_path_connect);
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------

  // next values of gain, io and configuration
  always_comb
  begin
    gain_next = gain_reg;
    io_next = io_reg;
    lsb_first_next = lsb_first_reg;
    force_low_next = force_low_reg;
    case (cmd_kind)
      dsp_ctrl_pkg::CMD_GAIN:
      begin
        // both fields from one byte, no cross effect
        gain_next.rx_step = cmd_byte[`GAIN_RX_MSB:`GAIN_RX_LSB];
        gain_next.tx_step = cmd_byte[`GAIN_TX_MSB:`GAIN_TX_LSB];
      end
      dsp_ctrl_pkg::CMD_IO:
      begin
        io_next = cmd_io;
      end
      dsp_ctrl_pkg::CMD_NONE:
      begin
        gain_next = gain_reg;
      end
      default:
      begin
        gain_next = gain_reg;
      end
    endcase
    if (reg_wr && (reg_addr == `OFF_CONFIG))
    begin
      lsb_first_next = reg_wdata[`CFG_LSB_FIRST_BIT];
      force_low_next = reg_wdata[`CFG_FORCE_LOW_BIT];
    end
  end

  // register control state
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      gain_reg <= dsp_ctrl_pkg::gain_s'(5'(`GAIN_CMD_RESET));
      io_reg <= dsp_ctrl_pkg::io_ctrl_s'(4'(`IO_CMD_RESET));
      lsb_first_reg <= 1'b0;
      force_low_reg <= 1'b1;
    end
    else
    begin
      gain_reg <= gain_next;
      io_reg <= io_next;
      lsb_first_reg <= lsb_first_next;
      force_low_reg <= force_low_next;
    end
  end

  // ----------------------------------------------------------------
  // sticky status
  // ----------------------------------------------------------------

  // write one clears; a new event in the same cycle wins
  always_comb
  begin
    bad_cmd_next = bad_cmd_reg;
    inhibit_next = inhibit_reg;
    tone_live_next = tone_live_reg;
    if (sts_wr)
    begin
      bad_cmd_next = bad_cmd_reg && !reg_wdata[`STS_BAD_CMD_BIT];
      inhibit_next = inhibit_reg && !reg_wdata[`STS_INHIBIT_BIT];
      tone_live_next = tone_live_reg && !reg_wdata[`STS_TONE_LIVE_BIT];
    end
    if (cmd_wr && (cmd_kind == dsp_ctrl_pkg::CMD_NONE))
    begin
      bad_cmd_next = 1'b1;
    end
    if (cmd_kind == dsp_ctrl_pkg::CMD_IO)
    begin
      if (cmd_inhibited)
      begin
        inhibit_next = 1'b1;
      end
      if (tone_switch_live)
      begin
        tone_live_next = 1'b1;
      end
    end
  end

  // register status flags
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bad_cmd_reg <= 1'b0;
      inhibit_reg <= 1'b0;
      tone_live_reg <= 1'b0;
    end
    else
    begin
      bad_cmd_reg <= bad_cmd_next;
      inhibit_reg <= inhibit_next;
      tone_live_reg <= tone_live_next;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------

  // read mux; data stand only in the cycle after the strobe
  always_comb
  begin
    rdata_next = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `OFF_GAIN_VIEW:
        begin
          rdata_next = {`GAIN_PREFIX, gain_reg};
        end
        `OFF_IO_VIEW:
        begin
          rdata_next = {`IO_PREFIX, io_reg};
        end
        `OFF_CONFIG:
        begin
          rdata_next = {6'h00, force_low_reg, lsb_first_reg};
        end
        `OFF_STATUS:
        begin
          rdata_next = {5'h00, tone_live_reg, inhibit_reg, bad_cmd_reg};
        end
        default:
        begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // register read data
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // datapath steering
  // ----------------------------------------------------------------

  // serial pins, path enables and attenuation in 0.4 dB units
  always_comb
  begin
    // receive steps are 0.8 dB, send steps 0.4 dB
    rx_att_next = {1'b0, gain_reg.rx_step, 1'b0};
    tx_att_next = {1'b0, gain_reg.tx_step};
    // band-pass runs with the filter bit
    // send processing needs serial out enabled
    path_next.send_proc_run = io_reg.serial_out_drive;
    path_next.receive_in_run = io_reg.serial_in_accept;
    // tone into send only with filter off
    path_next.tone_to_send = !io_reg.send_filter_run && io_reg.tone_path_connect;
    // tone joins the receive side too
    path_next.tone_to_receive = io_reg.tone_path_connect;
    if (force_low_reg || !io_reg.serial_out_drive)
    begin
      so_next = 1'b0;
    end
    else if (io_reg.send_filter_run)
    begin
      so_next = send_bit;
    end
    else if (path_next.tone_to_send)
    begin
      so_next = tone_bit;
    end
    else
    begin
      so_next = 1'b0;
    end
    // serial input seen low unless accepted
    rx_next = (io_reg.serial_in_accept && !force_low_reg) ? si_pin : 1'b0;
  end

  // register datapath outputs
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      so_reg <= 1'b0;
      rx_reg <= 1'b0;
      path_reg <= '0;
      rx_att_reg <= 4'h0;
      tx_att_reg <= 4'h0;
    end
    else
    begin
      so_reg <= so_next;
      rx_reg <= rx_next;
      path_reg <= path_next;
      rx_att_reg <= rx_att_next;
      tx_att_reg <= tx_att_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_reg;
  assign so_pin = so_reg;
  assign rx_bit = rx_reg;
  assign dsp_gain = gain_reg;
  assign io_ctrl = io_reg;
  assign path_en = path_reg;
  assign rx_atten = rx_att_reg;
  assign tx_atten = tx_att_reg;

endmodule : dsp_gain_io_ctrl
